// *** verilog/radio_interrupt_mask_status.sv ***
// Interrupt enable, flag, polarity and timestamp pin logic of the radio.
//
// Behaviour
// - Eight-bit enable register, bit n enables event n.
// - Enables clear to zero on any reset.
// - Flag read returns flags, clears them, drops request.
// - No enables, no polling: no request, no flags.
// - No enables, polling: no request, flags recorded.
// - Enabled events request and flag; masked need polling.
// - Control bit 1 selects polling mode.
// - Polled-only events never drive the request pin.
// - Control bit 0 selects request pin polarity.
// - Buffer-empty indicator stays active high always.
// - Polarity does not alter indicator enable behaviour.
// - Indicator takes the request pin during reads.
// - Control bit 6 enables timestamp pin.
// - Timestamp rises at frame header reception.
// - Timestamp stays high until frame ends.
// - Timestamp works without frame-start enable.
// - Pending enabled flags OR onto request pin.
// - Flags stick until a flag register read or a reset; lock and unlock also clear each other.
// - Lock and unlock events clear each other.
`timescale 1ns/1ns
module radio_interrupt_mask_status (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_reset,
	// Register port
	input wire logic [radio_irq_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [radio_irq_pkg::DATA_W-1:0] reg_wdata,
	output logic [radio_irq_pkg::DATA_W-1:0] reg_rdata,
	// Event sources
	input wire logic [radio_irq_pkg::DATA_W-1:0] event_in,
	input wire logic phr_received,
	input wire logic frame_done,
	// Frame buffer empty indicator
	input wire logic buffer_empty_indicator_enable,
	input wire logic frame_buffer_read_active,
	input wire logic buffer_empty,
	// Pins
	output logic irq_pin,
	output logic timestamp_pin
);

	// ********************************************************************
	// Register decode
	// ********************************************************************

	function automatic logic reg_hit(
		input logic [radio_irq_pkg::ADDR_W-1:0] addr,
		input logic [radio_irq_pkg::ADDR_W-1:0] offset
	);
		reg_hit = (addr == offset);
	endfunction

	logic [radio_irq_pkg::DATA_W-1:0] enable;
	logic [radio_irq_pkg::DATA_W-1:0] flags;
	logic irq_polarity;
	logic mask_mode;
	logic timestamp_output_enable;
	logic flag_read;
	logic bei_route;
	radio_irq_pkg::ts_state_t ts_state;
	radio_irq_pkg::ts_state_t next_ts_state;

	assign flag_read = reg_rd && reg_hit(reg_addr, radio_irq_pkg::OFS_INTERRUPT_FLAGS);

	// The indicator overrides the request function only while it is enabled
	// and the host is reading the frame buffer.
	assign bei_route = buffer_empty_indicator_enable && frame_buffer_read_active;

	// ********************************************************************
	// Enable register
	// ********************************************************************

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable <= radio_irq_pkg::RST_INTERRUPT_ENABLE;
		end else if (soft_reset) begin
			enable <= radio_irq_pkg::RST_INTERRUPT_ENABLE;
		end else if (reg_wr && reg_hit(reg_addr, radio_irq_pkg::OFS_INTERRUPT_ENABLE)) begin
			enable <= reg_wdata;
		end
	end

	// ********************************************************************
	// Control register
	// ********************************************************************

	// Only the three interrupt-related bits are held here; the others of
	// this register belong to other blocks and read back as zero.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_polarity <= radio_irq_pkg::RST_IRQ_POLARITY;
			mask_mode <= radio_irq_pkg::RST_MASK_MODE;
			timestamp_output_enable <= radio_irq_pkg::RST_TIMESTAMP_OUTPUT_ENABLE;
		end else if (soft_reset) begin
			irq_polarity <= radio_irq_pkg::RST_IRQ_POLARITY;
			mask_mode <= radio_irq_pkg::RST_MASK_MODE;
			timestamp_output_enable <= radio_irq_pkg::RST_TIMESTAMP_OUTPUT_ENABLE;
		end else if (reg_wr
				&& reg_hit(reg_addr, radio_irq_pkg::OFS_TRANSCEIVER_CONTROL_ONE)) begin
			irq_polarity <= reg_wdata[radio_irq_pkg::BIT_IRQ_POLARITY];
			mask_mode <= reg_wdata[radio_irq_pkg::BIT_MASK_MODE];
			timestamp_output_enable <=
				reg_wdata[radio_irq_pkg::BIT_TIMESTAMP_OUTPUT_ENABLE];
		end
	end

	// ********************************************************************
	// Flags
	// ********************************************************************

	flag_collector flag_store (
		.core_clk(core_clk),
		.rst(rst),
		.soft_reset(soft_reset),
		.event_in(event_in),
		.enable(enable),
		.mask_mode(mask_mode),
		.read_clear(flag_read),
		.flags(flags)
	);

	// ********************************************************************
	// Read data
	// ********************************************************************

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= radio_irq_pkg::RST_READ_DATA;
		end else if (reg_rd) begin
			if (reg_hit(reg_addr, radio_irq_pkg::OFS_INTERRUPT_ENABLE)) begin
				reg_rdata <= enable;
			end else if (flag_read) begin
				reg_rdata <= flags;
			end else if (reg_hit(reg_addr, radio_irq_pkg::OFS_TRANSCEIVER_CONTROL_ONE)) begin
				reg_rdata <= '0;
				reg_rdata[radio_irq_pkg::BIT_IRQ_POLARITY] <= irq_polarity;
				reg_rdata[radio_irq_pkg::BIT_MASK_MODE] <= mask_mode;
				reg_rdata[radio_irq_pkg::BIT_TIMESTAMP_OUTPUT_ENABLE] <= timestamp_output_enable;
			end else begin
				reg_rdata <= '0;
			end
		end
	end

	// ********************************************************************
	// Request pin
	// ********************************************************************

	// Masked flags are excluded, so polled-only events never raise the pin.
	// The indicator path bypasses the polarity bit and is always active high.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_pin <= 1'b0;
		end else if (bei_route) begin
			irq_pin <= buffer_empty;
		end else begin
			irq_pin <= (|(flags & enable)) ^ irq_polarity;
		end
	end

	// ********************************************************************
	// Timestamp pin
	// ********************************************************************

	// Independent of the frame-start enable bit. A header arriving in the
	// same cycle as a frame end starts a new high period.
	always_comb begin
		next_ts_state = ts_state;
		case (ts_state)
			radio_irq_pkg::TS_LOW: begin
				if (timestamp_output_enable && phr_received) begin
					next_ts_state = radio_irq_pkg::TS_HIGH;
				end
			end
			radio_irq_pkg::TS_HIGH: begin
				if (!timestamp_output_enable) begin
					next_ts_state = radio_irq_pkg::TS_LOW;
				end else if (frame_done && !phr_received) begin
					next_ts_state = radio_irq_pkg::TS_LOW;
				end
			end
			default: begin
				next_ts_state = radio_irq_pkg::TS_LOW;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ts_state <= radio_irq_pkg::TS_LOW;
		end else if (soft_reset) begin
			ts_state <= radio_irq_pkg::TS_LOW;
		end else begin
			ts_state <= next_ts_state;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			timestamp_pin <= 1'b0;
		end else if (soft_reset) begin
			timestamp_pin <= 1'b0;
		end else begin
			timestamp_pin <= (next_ts_state == radio_irq_pkg::TS_HIGH);
		end
	end

	// ********************************************************************
	// Assertions
	// ********************************************************************

	property p_enable_reset;
		@(posedge core_clk) disable iff (rst)
		soft_reset |=> (enable == radio_irq_pkg::RST_INTERRUPT_ENABLE);
	endproperty
	a_enable_reset: assert property (p_enable_reset) else $error("enable not cleared");

	property p_enable_write;
		@(posedge core_clk) disable iff (rst)
		(reg_wr && !soft_reset && reg_hit(reg_addr, radio_irq_pkg::OFS_INTERRUPT_ENABLE))
		|=> (enable == $past(reg_wdata));
	endproperty
	a_enable_write: assert property (p_enable_write) else $error("enable write lost");

	property p_read_returns;
		@(posedge core_clk) disable iff (rst)
		flag_read |=> (reg_rdata == $past(flags));
	endproperty
	a_read_returns: assert property (p_read_returns) else $error("flag read data wrong");

	property p_read_clears;
		@(posedge core_clk) disable iff (rst)
		(flag_read && event_in == '0) |=> (flags == '0);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("flags not cleared");

	property p_no_record;
		@(posedge core_clk) disable iff (rst)
		(enable == '0 && !mask_mode) |=> ((flags & ~$past(flags)) == '0);
	endproperty
	a_no_record: assert property (p_no_record) else $error("flag set while masked");

	property p_polled_record;
		@(posedge core_clk) disable iff (rst)
		(mask_mode && !soft_reset) |=> ((flags & $past(event_in)) == $past(event_in));
	endproperty
	a_polled_record: assert property (p_polled_record) else $error("polled event lost");

	property p_enabled_record;
		@(posedge core_clk) disable iff (rst)
		(!soft_reset && |(event_in & enable))
		|=> ((flags & $past(event_in & enable)) == $past(event_in & enable));
	endproperty
	a_enabled_record: assert property (p_enabled_record) else $error("enabled event lost");

	property p_request_or;
		@(posedge core_clk) disable iff (rst)
		!bei_route |=> (irq_pin == ((|$past(flags & enable)) ^ $past(irq_polarity)));
	endproperty
	a_request_or: assert property (p_request_or) else $error("request pin wrong");

	property p_indicator;
		@(posedge core_clk) disable iff (rst)
		bei_route |=> (irq_pin == $past(buffer_empty));
	endproperty
	a_indicator: assert property (p_indicator) else $error("indicator pin wrong");

	property p_sticky;
		@(posedge core_clk) disable iff (rst)
		(!flag_read && !soft_reset && event_in == '0) |=> (flags == $past(flags));
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped");

	property p_lock_clears_unlock;
		@(posedge core_clk) disable iff (rst)
		(event_in[radio_irq_pkg::EVT_SYNTH_LOCK] && !event_in[radio_irq_pkg::EVT_SYNTH_UNLOCK])
		|=> !flags[radio_irq_pkg::EVT_SYNTH_UNLOCK];
	endproperty
	a_lock_clears_unlock: assert property (p_lock_clears_unlock) else $error("unlock kept");

	property p_ts_rise;
		@(posedge core_clk) disable iff (rst)
		(timestamp_output_enable && phr_received && !soft_reset) |=> timestamp_pin;
	endproperty
	a_ts_rise: assert property (p_ts_rise) else $error("timestamp did not rise");

	property p_ts_hold;
		@(posedge core_clk) disable iff (rst)
		(timestamp_pin && timestamp_output_enable && !frame_done && !soft_reset)
		|=> timestamp_pin;
	endproperty
	a_ts_hold: assert property (p_ts_hold) else $error("timestamp fell early");

	property p_ts_fall;
		@(posedge core_clk) disable iff (rst)
		(timestamp_pin && frame_done && !phr_received) |=> !timestamp_pin;
	endproperty
	a_ts_fall: assert property (p_ts_fall) else $error("timestamp stuck high");

	property p_ts_off;
		@(posedge core_clk) disable iff (rst)
		!timestamp_output_enable |=> !timestamp_pin;
	endproperty
	a_ts_off: assert property (p_ts_off) else $error("timestamp while disabled");

	// ********************************************************************
	// Coverage
	// ********************************************************************

	c_polled_only: cover property (@(posedge core_clk) disable iff (rst)
		(mask_mode && enable == '0 && event_in != '0) ##1 (flags != '0));
	c_read_with_event: cover property (@(posedge core_clk) disable iff (rst)
		(flag_read && event_in != '0));
	c_low_polarity: cover property (@(posedge core_clk) disable iff (rst)
		(irq_polarity && !irq_pin));
	c_frame_stamp: cover property (@(posedge core_clk) disable iff (rst)
		timestamp_pin ##1 !timestamp_pin);

endmodule

// *** pkg/radio_irq_pkg.sv ***
// Constants and types shared by the radio interrupt mask and status logic.
package radio_irq_pkg;

	// ********************************************************************
	// Register map
	// ********************************************************************
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] OFS_TRANSCEIVER_CONTROL_ONE = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE = 6'h0e;
	localparam logic [ADDR_W-1:0] OFS_INTERRUPT_FLAGS = 6'h0f;

	// ********************************************************************
	// Field positions
	// ********************************************************************
	localparam int BIT_IRQ_POLARITY = 0;
	localparam int BIT_MASK_MODE = 1;
	localparam int BIT_TIMESTAMP_OUTPUT_ENABLE = 6;
	localparam int EVT_SYNTH_LOCK = 0;
	localparam int EVT_SYNTH_UNLOCK = 1;
	localparam int EVT_FRAME_START = 2;
	localparam int EVT_LOW_BATTERY = 7;

	// ********************************************************************
	// Reset values
	// ********************************************************************
	localparam logic [DATA_W-1:0] RST_INTERRUPT_ENABLE = 8'h00;
	localparam logic [DATA_W-1:0] RST_INTERRUPT_FLAGS = 8'h00;
	localparam logic [DATA_W-1:0] RST_READ_DATA = 8'h00;
	localparam logic RST_IRQ_POLARITY = 1'b0;
	localparam logic RST_MASK_MODE = 1'b0;
	localparam logic RST_TIMESTAMP_OUTPUT_ENABLE = 1'b0;

	// ********************************************************************
	// Timestamp pin states
	// ********************************************************************
	typedef enum logic [0:0] {
		TS_LOW = 1'b0,
		TS_HIGH = 1'b1
	} ts_state_t;

endpackage

// *** verilog/flag_collector.sv ***
// Sticky interrupt flag register with clear-on-read and lock/unlock exclusion.
`timescale 1ns/1ns
module flag_collector (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	input wire logic soft_reset,
	// Event sources and masking
	input wire logic [radio_irq_pkg::DATA_W-1:0] event_in,
	input wire logic [radio_irq_pkg::DATA_W-1:0] enable,
	input wire logic mask_mode,
	// Clear request from a flag register read
	input wire logic read_clear,
	// Pending flags
	output logic [radio_irq_pkg::DATA_W-1:0] flags
);

	logic [radio_irq_pkg::DATA_W-1:0] record;
	logic [radio_irq_pkg::DATA_W-1:0] cross_clear;
	logic [radio_irq_pkg::DATA_W-1:0] keep;

	// Polling mode opens the gate for masked events as well.
	assign record = event_in & (enable | {radio_irq_pkg::DATA_W{mask_mode}});

	always_comb begin
		cross_clear = '0;
		cross_clear[radio_irq_pkg::EVT_SYNTH_UNLOCK] =
			event_in[radio_irq_pkg::EVT_SYNTH_LOCK];
		cross_clear[radio_irq_pkg::EVT_SYNTH_LOCK] =
			event_in[radio_irq_pkg::EVT_SYNTH_UNLOCK];
		keep = read_clear ? '0 : (flags & ~cross_clear);
	end

	// A new event always wins over a read that clears in the same cycle.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags <= radio_irq_pkg::RST_INTERRUPT_FLAGS;
		end else if (soft_reset) begin
			flags <= radio_irq_pkg::RST_INTERRUPT_FLAGS;
		end else begin
			flags <= keep | record;
		end
	end

endmodule

// *** sim/host_model.sv ***
// Host microcontroller model that drives the register port of the interrupt block.
`timescale 1ns/1ns
module host_model (
	// Clock
	input wire logic core_clk,
	// Register port
	output logic [radio_irq_pkg::ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [radio_irq_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [radio_irq_pkg::DATA_W-1:0] reg_rdata
);
	// ********************************************************************
	// Register accesses
	// ********************************************************************
	initial begin
		reg_addr = 6'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end

	// Each access starts on a falling edge, so two calls never drive a strobe twice at once.
	task automatic wr(input logic [5:0] addr, input logic [7:0] data);
		@(negedge core_clk);
		reg_addr = addr;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_wdata = ~data;
	endtask

	task automatic rd(input logic [5:0] addr, output logic [7:0] data);
		@(negedge core_clk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge core_clk);
		data = reg_rdata;
		reg_rd = 1'b0;
	endtask

	// Stale flags are thrown away before any source is armed.
	task automatic arm(input logic [7:0] en, input logic [7:0] ctrl);
		logic [7:0] stale;
		rd(radio_irq_pkg::OFS_INTERRUPT_FLAGS, stale);
		wr(radio_irq_pkg::OFS_TRANSCEIVER_CONTROL_ONE, ctrl);
		wr(radio_irq_pkg::OFS_INTERRUPT_ENABLE, en);
	endtask
endmodule

// *** sim/radio_interrupt_mask_status_tb.sv ***
// Self-checking testbench of the radio interrupt mask and status block.
`timescale 1ns/1ns
module radio_interrupt_mask_status_tb;
	localparam logic [5:0] A_CTL = radio_irq_pkg::OFS_TRANSCEIVER_CONTROL_ONE;
	localparam logic [5:0] A_EN = radio_irq_pkg::OFS_INTERRUPT_ENABLE;
	localparam logic [5:0] A_FL = radio_irq_pkg::OFS_INTERRUPT_FLAGS;
	logic core_clk, rst, soft_reset, reg_wr, reg_rd, irq_pin, timestamp_pin;
	logic phr_received, frame_done, buffer_empty_indicator_enable;
	logic frame_buffer_read_active, buffer_empty;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, event_in;
	int n_mismatch = 0;
	int compares = 0;

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	radio_interrupt_mask_status i_dut (.core_clk(core_clk), .rst(rst), .soft_reset(soft_reset),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .event_in(event_in), .phr_received(phr_received),
		.frame_done(frame_done), .buffer_empty_indicator_enable(buffer_empty_indicator_enable),
		.frame_buffer_read_active(frame_buffer_read_active), .buffer_empty(buffer_empty),
		.irq_pin(irq_pin), .timestamp_pin(timestamp_pin));

	host_model i_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// ********************************************************************
	// Helpers
	// ********************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rd(input logic [5:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(addr, d);
		chk(d, exp);
	endtask

	// The pulse is over and the pin has had its one extra cycle when this returns.
	task automatic evt(input logic [7:0] v);
		event_in = v;
		@(negedge core_clk);
		event_in = 8'h00;
		@(negedge core_clk);
	endtask

	task automatic summarize;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ********************************************************************
	// Scenarios
	// ********************************************************************
	task automatic t_regs;
		chk_rd(A_EN, 8'h00);
		chk_rd(A_CTL, 8'h00);
		chk_rd(6'h10, 8'h00);
		chk_rd(A_FL, 8'h00);
		i_host.wr(A_EN, 8'ha5);
		chk_rd(A_EN, 8'ha5);
		i_host.wr(A_FL, 8'hff);
		chk_rd(A_FL, 8'h00);
		i_host.wr(A_CTL, 8'hff);
		chk_rd(A_CTL, 8'h43);
		@(negedge core_clk);
		soft_reset = 1'b1;
		@(negedge core_clk);
		soft_reset = 1'b0;
		chk_rd(A_EN, 8'h00);
		chk_rd(A_CTL, 8'h00);
	endtask

	task automatic t_masked;
		i_host.arm(8'h00, 8'h00);
		evt(8'hff);
		chk({7'h00, irq_pin}, 8'h00);
		chk_rd(A_FL, 8'h00);
		i_host.arm(8'h00, 8'h02);
		evt(8'hfc);
		chk({7'h00, irq_pin}, 8'h00);
		chk_rd(A_FL, 8'hfc);
		chk_rd(A_FL, 8'h00);
	endtask

	task automatic t_enabled;
		logic [7:0] b;
		for (int n = 0; n < 8; n++) begin
			b = 8'h01 << n;
			i_host.arm(b, 8'h00);
			evt(~b);
			chk({7'h00, irq_pin}, 8'h00);
			evt(b);
			repeat (4) @(negedge core_clk);
			chk({7'h00, irq_pin}, 8'h01);
			chk_rd(A_FL, b);
			@(negedge core_clk);
			chk({7'h00, irq_pin}, 8'h00);
		end
		i_host.arm(8'h80, 8'h02);
		evt(8'hfc);
		chk({7'h00, irq_pin}, 8'h01);
		chk_rd(A_FL, 8'hfc);
	endtask

	task automatic t_polarity;
		for (int p = 0; p < 2; p++) begin
			i_host.arm(8'h08, p[7:0]);
			@(negedge core_clk);
			chk({7'h00, irq_pin}, p[7:0]);
			evt(8'h08);
			chk({7'h00, irq_pin}, {7'h00, ~p[0]});
			buffer_empty_indicator_enable = 1'b1;
			buffer_empty = 1'b1;
			@(negedge core_clk);
			chk({7'h00, irq_pin}, {7'h00, ~p[0]});
			frame_buffer_read_active = 1'b1;
			@(negedge core_clk);
			chk({7'h00, irq_pin}, 8'h01);
			buffer_empty = 1'b0;
			@(negedge core_clk);
			chk({7'h00, irq_pin}, 8'h00);
			frame_buffer_read_active = 1'b0;
			@(negedge core_clk);
			chk({7'h00, irq_pin}, {7'h00, ~p[0]});
			buffer_empty_indicator_enable = 1'b0;
		end
	endtask

	task automatic t_timestamp;
		i_host.arm(8'h00, 8'h00);
		phr_received = 1'b1;
		@(negedge core_clk);
		phr_received = 1'b0;
		@(negedge core_clk);
		chk({7'h00, timestamp_pin}, 8'h00);
		i_host.arm(8'h00, 8'h40);
		phr_received = 1'b1;
		@(negedge core_clk);
		phr_received = 1'b0;
		chk({7'h00, timestamp_pin}, 8'h01);
		repeat (5) @(negedge core_clk);
		chk({7'h00, timestamp_pin}, 8'h01);
		frame_done = 1'b1;
		@(negedge core_clk);
		frame_done = 1'b0;
		chk({7'h00, timestamp_pin}, 8'h00);
	endtask

	task automatic t_cross;
		i_host.arm(8'h00, 8'h02);
		evt(8'h01);
		evt(8'h02);
		chk_rd(A_FL, 8'h02);
		evt(8'h02);
		evt(8'h01);
		chk_rd(A_FL, 8'h01);
	endtask

	// ********************************************************************
	// Main sequence
	// ********************************************************************
	initial begin
		rst = 1'b1;
		soft_reset = 1'b0;
		event_in = 8'h00;
		phr_received = 1'b0;
		frame_done = 1'b0;
		buffer_empty_indicator_enable = 1'b0;
		frame_buffer_read_active = 1'b0;
		buffer_empty = 1'b0;
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		t_regs();
		t_masked();
		t_enabled();
		t_polarity();
		t_timestamp();
		t_cross();
		summarize();
	end

	// A hang is cut short well inside the run budget.
	initial begin
		repeat (20000) @(posedge core_clk);
		n_mismatch++;
		$display("mismatch at %0t: run limit, got %h expected %h", $time, 1'b0, 1'b1);
		summarize();
	end
endmodule
